// ---- hdl/rwc_defines.svh ----
// Purpose: Constants of the reset and watchdog controller
// Assumes: Bus clock clk_sys at 40 MHz
// Notes: Offsets, ranges and cycle counts
`ifndef RWC_DEFINES_SVH
`define RWC_DEFINES_SVH

`define RWC_CLK_NS 16'd25
`define RWC_POR_CYCLES 12'h0_FE0
`define RWC_PULLDOWN_CYCLES 3'h4
`define RWC_WDOG_ADDR 16'h3FF0
`define RWC_WDOG_CLEAR_BIT 0
`define RWC_IO_LO 16'h0000
`define RWC_IO_HI 16'h003F
`define RWC_GAP1_LO 16'h01C0
`define RWC_GAP1_HI 16'h023F
`define RWC_GAP2_LO 16'h02C0
`define RWC_GAP2_HI 16'h17FF
`define RWC_RDATA_RESET 8'h00

`endif

// ---- hdl/rwc_pkg.sv ----
// Purpose: Types of the reset and watchdog controller
// Assumes: Nothing beyond the defines header
// Notes: Power state is one-hot
package rwc_pkg;

    typedef enum logic [2:0] {
        RWC_RUN = 3'b001,
        RWC_STOP = 3'b010,
        RWC_START = 3'b100
    } rwc_pwr_t;

endpackage

// ---- hdl/rwc_reset_ctrl.sv ----
// Purpose: Combines all reset sources into one internal reset
// Assumes: Inputs synchronous to clk_sys; resetn is the power-up event
// Notes: Open-drain reset pin as input, output and enable
`include "rwc_defines.svh"

module rwc_reset_ctrl
    import rwc_pkg::*;
#(
    parameter bit WDOG_ENABLE = 1'b1,
    parameter bit LVR_ENABLE = 1'b1,
    parameter bit STOP_DISABLE = 1'b0,
    parameter logic [15:0] WDOG_TIMEOUT = 16'hFFFF,
    // Arbitrary user byte programmed at the watchdog location
    parameter logic [7:0] WDOG_USER_BYTE = 8'h00
) (
    // Clock and power-up event
    input wire logic clk_sys,
    input wire logic resetn,

    // Open-drain reset pin
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOe,

    // Oscillator and supply sensing
    input wire logic oscActive,
    input wire logic supplyBelowLower,
    input wire logic supplyAboveUpper,

    // Core status
    input wire logic fetchValid,
    input wire logic [15:0] fetchAddr,
    input wire logic stopExec,
    input wire logic stopWakeIrq,

    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,

    // Reset and power state towards the core
    output logic sysResetn,
    output logic modeUpdate,
    output logic stopMode
);

    function automatic logic inRange(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic isIllegal(input logic [15:0] a);
        isIllegal = inRange(a, `RWC_IO_LO, `RWC_IO_HI) ||
                    inRange(a, `RWC_GAP1_LO, `RWC_GAP1_HI) ||
                    inRange(a, `RWC_GAP2_LO, `RWC_GAP2_HI);
    endfunction

    // Last count of a power-up length delay
    function automatic logic delayDone(input logic [11:0] cnt);
        delayDone = (cnt == `RWC_POR_CYCLES - 12'h0_001);
    endfunction

    // Decode of the watchdog clear location
    function automatic logic isWdogAddr(input logic [15:0] a);
        isWdogAddr = (a == `RWC_WDOG_ADDR);
    endfunction

    // Power state
    rwc_pwr_t pwr;
    logic [11:0] startCnt;
    logic startByReset;
    logic startHold;
    logic stopEnter;

    // Reset pin sampling and echo of our own pulldown
    logic pinSync1;
    logic pinSync2;
    logic drvSync1;
    logic drvSync2;
    logic extLatch;
    logic extActive;

    // Power-up and low-voltage sources
    logic porActive;
    logic [11:0] porCnt;
    logic lvrLow;
    logic lvrActive;
    logic [11:0] lvrCnt;

    // Watchdog
    logic [15:0] wdCnt;
    logic [15:0] next_wdCnt;
    logic wdFire;
    logic next_wdFire;
    logic wdClearWrite;

    // One-cycle traps
    logic illegalHit;
    logic stopTrap;

    // Combining and pulldown
    logic intActive;
    logic anyActive;
    logic anyPrev;
    logic holdReset;
    logic [2:0] pdCnt;
    logic modalSeen;

    // Pin drives only low; the enable decides
    assign resetPinOut = 1'b0;
    assign stopMode = (pwr == RWC_STOP);

    // Two-stage synchroniser on the reset pin
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pinSync1 <= 1'b1;
            pinSync2 <= 1'b1;
        end else begin
            pinSync1 <= resetPinIn;
            pinSync2 <= pinSync1;
        end
    end

    // Own pulldown delayed like the pin, so that its echo
    // on the pin is not taken for an external reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            drvSync1 <= 1'b1;
            drvSync2 <= 1'b1;
        end else begin
            drvSync1 <= !resetPinOe;
            drvSync2 <= drvSync1;
        end
    end

    // A pin low seen before our pulldown began stays external
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            extLatch <= 1'b0;
        end else begin
            extLatch <= extActive;
        end
    end

    assign extActive = !pinSync2 && (!drvSync2 || extLatch);

    // Power-up delay counted once the oscillator runs
    // Counting pauses while the oscillator is stopped
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            porActive <= 1'b1;
            porCnt <= 12'h0_000;
        end else if (porActive && oscActive) begin
            if (delayDone(porCnt)) begin
                porActive <= 1'b0;
            end else begin
                porCnt <= porCnt + 12'h0_001;
            end
        end
    end

    // Low-voltage reset, released after a full power-up delay
    // Count restarts whenever the supply dips again
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lvrLow <= 1'b0;
            lvrCnt <= 12'h0_000;
        end else if (!LVR_ENABLE) begin
            lvrLow <= 1'b0;
            lvrCnt <= 12'h0_000;
        end else if (supplyBelowLower) begin
            // Sensed in every power state
            lvrLow <= 1'b1;
            lvrCnt <= 12'h0_000;
        end else if (lvrLow && supplyAboveUpper) begin
            if (delayDone(lvrCnt)) begin
                lvrLow <= 1'b0;
                lvrCnt <= 12'h0_000;
            end else begin
                lvrCnt <= lvrCnt + 12'h0_001;
            end
        end else if (lvrLow) begin
            lvrCnt <= 12'h0_000;
        end
    end

    assign lvrActive = lvrLow;

    // Only a zero in the clear bit restarts the watchdog
    assign wdClearWrite = regWrite && isWdogAddr(regAddr) &&
                          !regWdata[`RWC_WDOG_CLEAR_BIT];

    // Watchdog counter, next value
    always_comb begin
        // Runs in RUN and interrupt startup alike
        next_wdCnt = wdCnt + 16'h0001;
        next_wdFire = 1'b0;
        if (!WDOG_ENABLE) begin
            next_wdCnt = 16'h0000;
        end else if (!sysResetn || wdClearWrite) begin
            next_wdCnt = 16'h0000;
        end else if (pwr == RWC_STOP || stopEnter) begin
            next_wdCnt = 16'h0000;
        end else if (pwr == RWC_START && startByReset) begin
            next_wdCnt = 16'h0000;
        end else if (wdCnt == WDOG_TIMEOUT - 16'h0001) begin
            next_wdCnt = 16'h0000;
            next_wdFire = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wdCnt <= 16'h0000;
            wdFire <= 1'b0;
        end else begin
            wdCnt <= next_wdCnt;
            wdFire <= next_wdFire;
        end
    end

    // One-cycle internal trap sources
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            illegalHit <= 1'b0;
            stopTrap <= 1'b0;
        end else begin
            illegalHit <= fetchValid && isIllegal(fetchAddr);
            stopTrap <= stopExec && STOP_DISABLE;
        end
    end

    // STOP is entered only from RUN and only when not trapped
    assign stopEnter = stopExec && !STOP_DISABLE && (pwr == RWC_RUN);
    // Startup after a reset exit from STOP counts as a source
    assign intActive = porActive || lvrActive || wdFire || illegalHit ||
                       stopTrap || startHold;
    assign anyActive = intActive || extActive;
    // A pin still low, whatever drives it, keeps the core in reset
    assign holdReset = anyActive || (pdCnt != 3'h0) || !pinSync2;

    // Power state: STOP and its startup delay
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pwr <= RWC_RUN;
            startCnt <= 12'h0_000;
            startByReset <= 1'b0;
        end else begin
            unique case (pwr)
                RWC_RUN: begin
                    if (stopEnter) begin
                        pwr <= RWC_STOP;
                    end
                end

                RWC_STOP: begin
                    startCnt <= 12'h0_000;
                    if (anyActive) begin
                        pwr <= RWC_START;
                        startByReset <= 1'b1;
                    end else if (stopWakeIrq) begin
                        pwr <= RWC_START;
                        startByReset <= 1'b0;
                    end
                end

                RWC_START: begin
                    if (delayDone(startCnt)) begin
                        pwr <= RWC_RUN;
                        startByReset <= 1'b0;
                    end else begin
                        startCnt <= startCnt + 12'h0_001;
                    end
                end
            endcase
        end
    end

    assign startHold = (pwr == RWC_START) && startByReset;

    // Pulldown timer restarted by the first edge of any source
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            anyPrev <= 1'b1;
            pdCnt <= `RWC_PULLDOWN_CYCLES;
        end else begin
            anyPrev <= anyActive;
            if (anyActive && !anyPrev) begin
                pdCnt <= `RWC_PULLDOWN_CYCLES;
            end else if (pdCnt != 3'h0) begin
                pdCnt <= pdCnt - 3'h1;
            end
        end
    end

    // External source alone never extends the pulldown
    // Pin-visible window is pdCnt at 4, 3 and 2
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            resetPinOe <= 1'b0;
        end else begin
            resetPinOe <= !((pdCnt > 3'h1) || intActive);
        end
    end

    // Single combined reset, released on a clock edge
    // Released only once the pin is back high as well
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sysResetn <= 1'b0;
        end else begin
            sysResetn <= !holdReset;
        end
    end

    // Mode update only after pin or watchdog resets
    // Pulse lands on the edge that releases the reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            modalSeen <= 1'b0;
            modeUpdate <= 1'b0;
        end else begin
            modeUpdate <= 1'b0;
            if (extActive || wdFire) begin
                modalSeen <= 1'b1;
            end else if (!sysResetn && !holdReset) begin
                modeUpdate <= modalSeen;
                modalSeen <= 1'b0;
            end
        end
    end

    // Read returns the stored user byte, never watchdog state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            regRdata <= `RWC_RDATA_RESET;
        end else if (regRead && isWdogAddr(regAddr)) begin
            regRdata <= WDOG_USER_BYTE;
        end else begin
            regRdata <= `RWC_RDATA_RESET;
        end
    end

endmodule // rwc_reset_ctrl

// ---- tb/rwc_reset_ctrl_monitor.sv ----
// Purpose: Concurrent checks on the reset controller ports
// Assumes: One clock domain, async active-low resetn
// Notes: Bound to every rwc_reset_ctrl instance
`include "rwc_defines.svh"
module rwc_reset_ctrl_monitor #(
    parameter logic [15:0] WDOG_TIMEOUT = 16'hFFFF,
    parameter logic [7:0] WDOG_USER_BYTE = 8'h00
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic resetPinIn,
    input wire logic resetPinOe,
    input wire logic fetchValid,
    input wire logic [15:0] fetchAddr,
    input wire logic stopMode,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic sysResetn
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [15:0] wdCnt;
    logic badFetch;
    assign badFetch = fetchAddr <= `RWC_IO_HI ||
        (fetchAddr >= `RWC_GAP1_LO && fetchAddr <= `RWC_GAP1_HI) ||
        (fetchAddr >= `RWC_GAP2_LO && fetchAddr <= `RWC_GAP2_HI);
    // Cycles run since the watchdog was last cleared
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            wdCnt <= 16'h0000;
        else if (!sysResetn || stopMode || (regWrite &&
                regAddr == `RWC_WDOG_ADDR && !regWdata[0]))
            wdCnt <= 16'h0000;
        else
            wdCnt <= wdCnt + 16'h0001;
    end
    sequence trapSeq;
        ##2 !sysResetn && !resetPinOe;
    endsequence
    rdata_idle_a: assert property (
        !regRead |=> regRdata == 8'h00) else $error("idle read data");
    rdata_user_a: assert property (
        regRead && regAddr == `RWC_WDOG_ADDR |=> regRdata == WDOG_USER_BYTE)
        else $error("watchdog location read data");
    pin_hold_a: assert property (
        !resetPinIn [*6] |-> !sysResetn) else $error("pin low, no reset");
    pulldown_min_a: assert property (
        $fell(resetPinOe) |-> !resetPinOe [*3]) else $error("short pulldown");
    pulldown_lead_a: assert property (
        $fell(resetPinOe) |-> ##[0:3] !sysResetn) else $error("no reset");
    fetch_trap_a: assert property (
        fetchValid && badFetch && sysResetn |-> trapSeq)
        else $error("illegal fetch not trapped");
    wdog_bound_a: assert property (
        sysResetn |-> wdCnt <= WDOG_TIMEOUT + 16'h0004)
        else $error("watchdog did not fire");
    stop_pin_a: assert property (
        stopMode && !resetPinIn |-> ##[1:4] !stopMode)
        else $error("pin reset did not leave stop");
endmodule // rwc_reset_ctrl_monitor

bind rwc_reset_ctrl rwc_reset_ctrl_monitor #(.WDOG_TIMEOUT(WDOG_TIMEOUT),
    .WDOG_USER_BYTE(WDOG_USER_BYTE)) rwc_reset_ctrl_monitor_inst (
    .clk_sys(clk_sys), .resetn(resetn), .resetPinIn(resetPinIn),
    .resetPinOe(resetPinOe), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
    .stopMode(stopMode), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .sysResetn(sysResetn));

// ---- tb/rwc_partner.sv ----
// Purpose: Reset pin network and CPU core beside the controller
// Assumes: Pin has a pull-up; CPU drives after rising edges
// Notes: Fetch and stop tasks are called by the bench
module rwc_partner (
    input wire logic clk_sys,
    input wire logic extLow,
    input wire logic resetPinOut,
    input wire logic resetPinOe,
    output logic resetPinIn,
    output logic fetchValid = 1'b0,
    output logic [15:0] fetchAddr = 16'h5A5A,
    output logic stopExec = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    // Wired-AND of button, device pulldown and pull-up
    assign resetPinIn = !(extLow || (!resetPinOe && !resetPinOut));
    task automatic fetch(input logic [15:0] a);
        @(posedge clk_sys);
        fetchValid <= 1'b1;
        fetchAddr <= a;
        @(posedge clk_sys);
        fetchValid <= 1'b0;
        fetchAddr <= ~a;
    endtask
    task automatic stop();
        @(posedge clk_sys);
        stopExec <= 1'b1;
        @(posedge clk_sys);
        stopExec <= 1'b0;
    endtask
endmodule // rwc_partner

// ---- tb/rwc_reset_ctrl_tb.sv ----
// Purpose: Self-checking bench of the reset controller
// Assumes: 40 MHz clk_sys, watchdog timeout shortened to 64
// Notes: Partner drives the pin network and CPU fetches
`include "rwc_defines.svh"
module rwc_reset_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] USER_BYTE = 8'hA5; // Arbitrary user byte
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic extLow = 1'b0;
    logic oscActive = 1'b0;
    logic supplyBelowLower = 1'b0;
    logic supplyAboveUpper = 1'b1;
    logic stopWakeIrq = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWdata = 8'h00;
    logic resetPinIn, resetPinOut, resetPinOe, fetchValid, stopExec;
    logic sysResetn, modeUpdate, stopMode;
    logic [15:0] fetchAddr;
    logic [7:0] regRdata;
    int error_cnt = 0;
    int cmp_count = 0;
    int modeCnt = 0;
    int cyc = 0;
    rwc_reset_ctrl #(.WDOG_TIMEOUT(16'h0040), .WDOG_USER_BYTE(USER_BYTE))
        rwc_reset_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn),
        .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
        .resetPinOe(resetPinOe), .oscActive(oscActive),
        .supplyBelowLower(supplyBelowLower),
        .supplyAboveUpper(supplyAboveUpper), .fetchValid(fetchValid),
        .fetchAddr(fetchAddr), .stopExec(stopExec),
        .stopWakeIrq(stopWakeIrq), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .sysResetn(sysResetn),
        .modeUpdate(modeUpdate), .stopMode(stopMode));
    rwc_partner rwc_partner_inst (.clk_sys(clk_sys), .extLow(extLow),
        .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
        .resetPinIn(resetPinIn), .fetchValid(fetchValid),
        .fetchAddr(fetchAddr), .stopExec(stopExec));
    initial forever #12.5 clk_sys = ~clk_sys;
    // Counted at the launching edge so checks right after release see it
    always @(posedge modeUpdate) modeCnt++;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 v = regRdata;
    endtask
    // Counts edges until the internal reset lets go, up to a limit
    task automatic waitRel(input int lim, output int n);
        n = 0;
        while (sysResetn !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_wdog();
        logic [7:0] v;
        int n;
        rd(`RWC_WDOG_ADDR, v);
        check(v, USER_BYTE);
        rd(16'h3FF1, v);
        check(v, 8'h00);
        repeat (4) begin
            wr(`RWC_WDOG_ADDR, 8'hFE);
            tick(48);
        end
        check(sysResetn, 1'b1);
        wr(`RWC_WDOG_ADDR, 8'hFE);
        tick(32);
        wr(`RWC_WDOG_ADDR, 8'h01);
        n = 34;
        while (sysResetn === 1'b1 && n < 90) begin
            tick(1);
            n++;
        end
        check(n >= 60 && n <= 72, 1'b1);
        waitRel(5000, n);
        check(modeCnt, 1);
        $display("watchdog done");
    endtask
    task automatic t_pin();
        int n;
        int pd;
        wr(`RWC_WDOG_ADDR, 8'h00);
        @(posedge clk_sys) extLow <= 1'b1;
        pd = 0;
        repeat (20) begin
            tick(1);
            pd += (resetPinOe === 1'b0);
        end
        check(pd >= 3 && pd <= 4, 1'b1);
        check(sysResetn, 1'b0);
        @(posedge clk_sys) extLow <= 1'b0;
        waitRel(20, n);
        check(sysResetn, 1'b1);
        check(modeCnt, 2);
        $display("pin done");
    endtask
    task automatic t_trap();
        logic [15:0] a [11] = '{16'h0000, 16'h003F, 16'h01C0, 16'h023F,
            16'h02C0, 16'h17FF, 16'h0040, 16'h01BF, 16'h0240, 16'h02BF,
            16'h1800};
        int n;
        foreach (a[i]) begin
            wr(`RWC_WDOG_ADDR, 8'h00);
            rwc_partner_inst.fetch(a[i]);
            tick(2);
            check(sysResetn, i > 5);
            waitRel(20, n);
        end
        check(modeCnt, 2);
        $display("fetch trap done");
    endtask
    task automatic t_stop();
        int n;
        wr(`RWC_WDOG_ADDR, 8'h00);
        rwc_partner_inst.stop();
        tick(200);
        check(stopMode, 1'b1);
        check(sysResetn, 1'b1);
        @(posedge clk_sys) stopWakeIrq <= 1'b1;
        @(posedge clk_sys) stopWakeIrq <= 1'b0;
        tick(60);
        check({stopMode, sysResetn}, 2'b01);
        tick(6);
        check(sysResetn, 1'b0);
        waitRel(5000, n);
        // Keep the watchdog fed until the startup delay is over
        repeat (90) begin
            wr(`RWC_WDOG_ADDR, 8'hFE);
            tick(46);
        end
        wr(`RWC_WDOG_ADDR, 8'h00);
        rwc_partner_inst.stop();
        @(posedge clk_sys) extLow <= 1'b1;
        tick(8);
        check(stopMode, 1'b0);
        @(posedge clk_sys) extLow <= 1'b0;
        waitRel(5000, n);
        check(n >= 4040 && n <= 4075, 1'b1);
        tick(56);
        check(sysResetn, 1'b1);
        $display("stop done");
    endtask
    task automatic t_lvr();
        int n;
        wr(`RWC_WDOG_ADDR, 8'h00);
        rwc_partner_inst.stop();
        supplyAboveUpper <= 1'b0;
        supplyBelowLower <= 1'b1;
        tick(4);
        check({stopMode, sysResetn}, 2'b00);
        supplyBelowLower <= 1'b0;
        supplyAboveUpper <= 1'b1;
        tick(1000);
        check(resetPinOe, 1'b0);
        supplyAboveUpper <= 1'b0;
        tick(1);
        supplyAboveUpper <= 1'b1;
        tick(4000);
        check(sysResetn, 1'b0);
        extLow <= 1'b1;
        tick(200);
        check(sysResetn, 1'b0);
        extLow <= 1'b0;
        waitRel(30, n);
        check(sysResetn, 1'b1);
        $display("low voltage done");
    endtask
    initial begin
        int n;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        tick(50);
        check(sysResetn, 1'b0);
        @(posedge clk_sys) oscActive <= 1'b1;
        tick(3000);
        check(resetPinOe, 1'b0);
        waitRel(2000, n);
        check(n >= 1063 && n <= 1068, 1'b1);
        check(modeCnt, 0);
        $display("power-up done");
        t_wdog();
        t_pin();
        t_trap();
        t_stop();
        t_lvr();
        summarize();
    end
endmodule // rwc_reset_ctrl_tb
